// *** rtl/port_f_pkg.sv ***
package port_f_pkg;

    // port geometry
    localparam int PORT_PIN_COUNT = 4;
    localparam int IRQ_LINE_COUNT = 16;
    localparam int SERIAL_LOOP_COUNT = 2;

    // register bus geometry
    localparam int BUS_ADDR_WIDTH = 8;
    localparam int BUS_DATA_WIDTH = 32;
    localparam int REG_WIDTH = 8;

    // byte addresses of the register words
    localparam logic [7:0] PIN_STATE_OFFSET = 8'h00;
    localparam logic [7:0] OUTPUT_LATCH_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_HIGH_SELECT_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_LOW_SELECT_OFFSET = 8'h0C;
    localparam logic [7:0] PORT_CONTROL_OFFSET = 8'h10;

    // reset values
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;
    localparam logic [7:0] IRQ_SELECT_RESET = 8'h00;
    localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;

    // port control zero field positions
    localparam int SMARTCARD_LOOP_CH1_BIT = 7;
    localparam int SMARTCARD_LOOP_CH3_BIT = 6;
    localparam int GLUELESS_STROBE_SELECT_BIT = 1;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/reg_access_if.sv ***
`timescale 1ns/1ps
interface reg_access_if;
    import port_f_pkg::*;
    logic wrEn;
    logic [BUS_ADDR_WIDTH-1:0] wrAddr;
    logic [REG_WIDTH-1:0] wrData;
    logic wrLane;
    logic wrErr;
    logic [BUS_ADDR_WIDTH-1:0] rdAddr;
    logic [REG_WIDTH-1:0] rdData;
    logic rdErr;

    modport bus (
        output wrEn, wrAddr, wrData, wrLane, rdAddr,
        input wrErr, rdData, rdErr
    );
    modport regs (
        input wrEn, wrAddr, wrData, wrLane, rdAddr,
        output wrErr, rdData, rdErr
    );
endinterface

// *** rtl/reg_bus_slave.sv ***
`timescale 1ns/1ps
module reg_bus_slave
    import port_f_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [BUS_ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [BUS_DATA_WIDTH-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [BUS_ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [BUS_DATA_WIDTH-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    reg_access_if.bus regs
);

    typedef struct packed {
        logic awHeld;
        logic [BUS_ADDR_WIDTH-1:0] awAddr;
        logic wHeld;
        logic [REG_WIDTH-1:0] wData;
        logic wLow;
        logic arHeld;
        logic [BUS_ADDR_WIDTH-1:0] arAddr;
        logic awReady;
        logic wReady;
        logic arReady;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [REG_WIDTH-1:0] rData;
        logic [1:0] rResp;
    } slave_state_t;

    slave_state_t state;
    slave_state_t next_state;

    always_comb begin
        next_state = state;
        if (awvalid && state.awReady) begin
            next_state.awHeld = 1'b1;
            next_state.awAddr = awaddr;
        end
        if (wvalid && state.wReady) begin
            next_state.wHeld = 1'b1;
            next_state.wData = wdata[REG_WIDTH-1:0];
            next_state.wLow = wstrb[0];
        end
        // write goes out once address and data are both held
        regs.wrEn = state.awHeld && state.wHeld && !state.bValid;
        regs.wrAddr = state.awAddr;
        regs.wrData = state.wData;
        regs.wrLane = state.wLow;
        if (regs.wrEn) begin
            next_state.awHeld = 1'b0;
            next_state.wHeld = 1'b0;
            next_state.bValid = 1'b1;
            next_state.bResp = regs.wrErr ? RESP_SLVERR : RESP_OKAY;
        end
        if (state.bValid && bready) begin
            next_state.bValid = 1'b0;
        end
        regs.rdAddr = state.arAddr;
        if (arvalid && state.arReady) begin
            next_state.arHeld = 1'b1;
            next_state.arAddr = araddr;
        end
        if (state.arHeld && !state.rValid) begin
            next_state.arHeld = 1'b0;
            next_state.rValid = 1'b1;
            next_state.rData = regs.rdData;
            next_state.rResp = regs.rdErr ? RESP_SLVERR : RESP_OKAY;
        end
        if (state.rValid && rready) begin
            next_state.rValid = 1'b0;
        end
        // one write and one read under way at a time
        next_state.awReady = !next_state.awHeld && !next_state.bValid;
        next_state.wReady = !next_state.wHeld && !next_state.bValid;
        next_state.arReady = !next_state.arHeld && !next_state.rValid;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign awready = state.awReady;
    assign wready = state.wReady;
    assign arready = state.arReady;
    assign bvalid = state.bValid;
    assign bresp = state.bResp;
    assign rvalid = state.rValid;
    assign rresp = state.rResp;
    assign rdata = {{(BUS_DATA_WIDTH-REG_WIDTH){1'b0}}, state.rData};

endmodule // reg_bus_slave

// *** rtl/port_f_and_pin_routing.sv ***
// Behaviour
// - a direction bit of 1 makes its pin an output, 0 makes it an input.
// - direction is write-only; its address reads back the live pin levels.
// - writing the pin-state address loads the direction latch.
// - direction and output latch clear on system reset, not on watchdog.
// - the output latch holds four read/write bits, reset 0, driven on pins.
// - bits 7 to 4 of output latch and pin state are reserved (read 0 here).
// - the pin-state read returns the synchronised live pin levels.
// - select bits 15 to 8 pick default (0) or alternate (1) irq pins.
// - select bits 7 to 0 pick default (0) or alternate (1) irq pins.
// - control bit 7 loops serial channel one transmit into its receive.
// - control bit 6 loops serial channel three transmit into its receive.
// - control bit 1 picks read plus upper/lower write or glueless strobes.
`timescale 1ns/1ps
module port_f_and_pin_routing
    import port_f_pkg::*;
#(
    parameter int PIN_COUNT = PORT_PIN_COUNT
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic watchdogReset,
    input wire logic [BUS_ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [BUS_DATA_WIDTH-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [BUS_ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [BUS_DATA_WIDTH-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [PIN_COUNT-1:0] pinLevelIn,
    output logic [PIN_COUNT-1:0] pinDriveOut,
    output logic [PIN_COUNT-1:0] pinDriveEnable,
    input wire logic [IRQ_LINE_COUNT-1:0] irqDefaultPin,
    input wire logic [IRQ_LINE_COUNT-1:0] irqAlternatePin,
    output logic [IRQ_LINE_COUNT-1:0] irqLine,
    input wire logic serial1TransmitLine,
    input wire logic serial1ReceivePin,
    output logic serial1ReceiveLine,
    input wire logic serial3TransmitLine,
    input wire logic serial3ReceivePin,
    output logic serial3ReceiveLine,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic busUpperByte,
    input wire logic busLowerByte,
    output logic readStrobeN,
    output logic upperWriteStrobeN,
    output logic lowerWriteStrobeN,
    output logic writeStrobeN,
    output logic upperByteEnableN,
    output logic lowerByteEnableN,
    output logic gluelessStrobeSelect
);

    typedef struct packed {
        logic [PIN_COUNT-1:0] direction;
        logic [PIN_COUNT-1:0] outputLatch;
        logic [PIN_COUNT-1:0] pinDrive;
        logic [PIN_COUNT-1:0] pinSyncA;
        logic [PIN_COUNT-1:0] pinSyncB;
        logic [REG_WIDTH-1:0] irqHighSelect;
        logic [REG_WIDTH-1:0] irqLowSelect;
        logic [REG_WIDTH-1:0] portControl;
        logic [IRQ_LINE_COUNT-1:0] defaultSyncA;
        logic [IRQ_LINE_COUNT-1:0] defaultSyncB;
        logic [IRQ_LINE_COUNT-1:0] alternateSyncA;
        logic [IRQ_LINE_COUNT-1:0] alternateSyncB;
        logic [IRQ_LINE_COUNT-1:0] irqRouted;
        logic [SERIAL_LOOP_COUNT-1:0] receiveSyncA;
        logic [SERIAL_LOOP_COUNT-1:0] receiveSyncB;
        logic [SERIAL_LOOP_COUNT-1:0] receiveRouted;
        logic readStrobeN;
        logic upperWriteStrobeN;
        logic lowerWriteStrobeN;
        logic writeStrobeN;
        logic upperByteEnableN;
        logic lowerByteEnableN;
    } port_state_t;

    localparam port_state_t STATE_RESET = '{
        direction: DIRECTION_RESET[PIN_COUNT-1:0],
        outputLatch: OUTPUT_LATCH_RESET[PIN_COUNT-1:0],
        irqHighSelect: IRQ_SELECT_RESET,
        irqLowSelect: IRQ_SELECT_RESET,
        portControl: PORT_CONTROL_RESET,
        readStrobeN: 1'b1,
        upperWriteStrobeN: 1'b1,
        lowerWriteStrobeN: 1'b1,
        writeStrobeN: 1'b1,
        upperByteEnableN: 1'b1,
        lowerByteEnableN: 1'b1,
        default: '0
    };

    port_state_t state;
    port_state_t next_state;

    reg_access_if regs ();

    reg_bus_slave u_bus (
        .clk(clk),
        .resetn(resetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regs(regs)
    );

    // per-line source selection between default and alternate pin
    logic [IRQ_LINE_COUNT-1:0] irqSelect;
    logic [IRQ_LINE_COUNT-1:0] irqChosen;

    assign irqSelect = {state.irqHighSelect, state.irqLowSelect};

    genvar line;
    generate
        for (line = 0; line < IRQ_LINE_COUNT; line++) begin : g_irq
            assign irqChosen[line] = irqSelect[line]
                ? state.alternateSyncB[line]
                : state.defaultSyncB[line];
        end
    endgenerate

    // register read decode
    always_comb begin
        regs.rdErr = 1'b0;
        regs.rdData = '0;
        case (regs.rdAddr)
            PIN_STATE_OFFSET: begin
                // live levels, not the stored direction bits
                regs.rdData = REG_WIDTH'(state.pinSyncB);
            end
            OUTPUT_LATCH_OFFSET: begin
                regs.rdData = REG_WIDTH'(state.outputLatch);
            end
            IRQ_HIGH_SELECT_OFFSET: begin
                regs.rdData = state.irqHighSelect;
            end
            IRQ_LOW_SELECT_OFFSET: begin
                regs.rdData = state.irqLowSelect;
            end
            PORT_CONTROL_OFFSET: begin
                regs.rdData = state.portControl;
            end
            default: begin
                regs.rdErr = 1'b1;
            end
        endcase
    end

    // write address check
    always_comb begin
        case (regs.wrAddr)
            PIN_STATE_OFFSET,
            OUTPUT_LATCH_OFFSET,
            IRQ_HIGH_SELECT_OFFSET,
            IRQ_LOW_SELECT_OFFSET,
            PORT_CONTROL_OFFSET: begin
                regs.wrErr = 1'b0;
            end
            default: begin
                regs.wrErr = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_state = state;

        // two-flop synchronisers for everything from pins
        next_state.pinSyncA = pinLevelIn;
        next_state.pinSyncB = state.pinSyncA;
        next_state.defaultSyncA = irqDefaultPin;
        next_state.defaultSyncB = state.defaultSyncA;
        next_state.alternateSyncA = irqAlternatePin;
        next_state.alternateSyncB = state.alternateSyncA;
        next_state.receiveSyncA = {serial3ReceivePin, serial1ReceivePin};
        next_state.receiveSyncB = state.receiveSyncA;

        // watchdog reset leaves the port latches alone
        if (watchdogReset) begin
            next_state.irqHighSelect = IRQ_SELECT_RESET;
            next_state.irqLowSelect = IRQ_SELECT_RESET;
            next_state.portControl = PORT_CONTROL_RESET;
        end else if (regs.wrEn && regs.wrLane) begin
            case (regs.wrAddr)
                PIN_STATE_OFFSET: begin
                    next_state.direction = regs.wrData[PIN_COUNT-1:0];
                end
                OUTPUT_LATCH_OFFSET: begin
                    next_state.outputLatch = regs.wrData[PIN_COUNT-1:0];
                end
                IRQ_HIGH_SELECT_OFFSET: begin
                    next_state.irqHighSelect = regs.wrData;
                end
                IRQ_LOW_SELECT_OFFSET: begin
                    next_state.irqLowSelect = regs.wrData;
                end
                PORT_CONTROL_OFFSET: begin
                    next_state.portControl = regs.wrData;
                end
                default: begin
                end
            endcase
        end

        // drive only pins set as outputs
        next_state.pinDrive = next_state.outputLatch
            & next_state.direction;

        next_state.irqRouted = irqChosen;

        next_state.receiveRouted[0] =
            state.portControl[SMARTCARD_LOOP_CH1_BIT]
            ? serial1TransmitLine
            : state.receiveSyncB[0];
        next_state.receiveRouted[1] =
            state.portControl[SMARTCARD_LOOP_CH3_BIT]
            ? serial3TransmitLine
            : state.receiveSyncB[1];

        // external extension strobes, all active low
        next_state.readStrobeN = !busRead;
        if (state.portControl[GLUELESS_STROBE_SELECT_BIT]) begin
            next_state.writeStrobeN = !busWrite;
            next_state.upperByteEnableN = !((busRead || busWrite)
                && busUpperByte);
            next_state.lowerByteEnableN = !((busRead || busWrite)
                && busLowerByte);
            next_state.upperWriteStrobeN = 1'b1;
            next_state.lowerWriteStrobeN = 1'b1;
        end else begin
            next_state.upperWriteStrobeN = !(busWrite && busUpperByte);
            next_state.lowerWriteStrobeN = !(busWrite && busLowerByte);
            next_state.writeStrobeN = 1'b1;
            next_state.upperByteEnableN = 1'b1;
            next_state.lowerByteEnableN = 1'b1;
        end
    end

    // only the system reset clears the port latches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign pinDriveEnable = state.direction;
    assign pinDriveOut = state.pinDrive;
    assign irqLine = state.irqRouted;
    assign serial1ReceiveLine = state.receiveRouted[0];
    assign serial3ReceiveLine = state.receiveRouted[1];
    assign readStrobeN = state.readStrobeN;
    assign upperWriteStrobeN = state.upperWriteStrobeN;
    assign lowerWriteStrobeN = state.lowerWriteStrobeN;
    assign writeStrobeN = state.writeStrobeN;
    assign upperByteEnableN = state.upperByteEnableN;
    assign lowerByteEnableN = state.lowerByteEnableN;
    assign gluelessStrobeSelect =
        state.portControl[GLUELESS_STROBE_SELECT_BIT];

endmodule // port_f_and_pin_routing

// *** tb/port_f_and_pin_routing_chk.sv ***
`timescale 1ns/1ps
module port_f_chk
    import port_f_pkg::*;
#(
    parameter int PIN_COUNT = PORT_PIN_COUNT
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [BUS_DATA_WIDTH-1:0] rdata,
    input wire logic [PIN_COUNT-1:0] pinDriveOut,
    input wire logic [PIN_COUNT-1:0] pinDriveEnable,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic busUpperByte,
    input wire logic busLowerByte,
    input wire logic readStrobeN,
    input wire logic upperWriteStrobeN,
    input wire logic writeStrobeN,
    input wire logic lowerByteEnableN,
    input wire logic gluelessStrobeSelect
);
    // checks start one edge after release so $past never sees pre-reset state
    logic armed;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!armed);

    input_no_drive_a: assert property (
        (pinDriveOut & ~pinDriveEnable) == '0)
        else $error("driver on input pin");
    enable_by_write_a: assert property (
        !$stable(pinDriveEnable) |-> $rose(bvalid))
        else $error("direction changed without write");
    latch_by_write_a: assert property (
        !$stable(pinDriveOut) |-> $rose(bvalid))
        else $error("drive level changed without write");
    read_strobe_a: assert property (
        readStrobeN == !$past(busRead))
        else $error("read strobe wrong");
    split_strobes_a: assert property (
        !$past(gluelessStrobeSelect) |-> writeStrobeN &&
        upperWriteStrobeN == !($past(busWrite) && $past(busUpperByte)))
        else $error("split write strobes wrong");
    glueless_strobes_a: assert property (
        $past(gluelessStrobeSelect) |-> upperWriteStrobeN &&
        lowerByteEnableN ==
        !(($past(busRead) || $past(busWrite)) && $past(busLowerByte)))
        else $error("glueless strobes wrong");
    write_answer_holds_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    read_answer_holds_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    read_upper_zero_a: assert property (
        rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule // port_f_chk

// *** tb/port_f_board.sv ***
`timescale 1ns/1ps
module port_f_board (
    input wire logic [3:0] pinDriveOut,
    input wire logic [3:0] pinDriveEnable,
    input wire logic [3:0] boardLevel,
    output logic [3:0] pinLevelIn
);
    // driven pins show the device level, released pins the board level
    assign pinLevelIn = (pinDriveEnable & pinDriveOut) |
        (~pinDriveEnable & boardLevel);
endmodule // port_f_board

// *** tb/port_f_and_pin_routing_bench.sv ***
`timescale 1ns/1ps
module port_f_and_pin_routing_bench;
    import port_f_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic watchdogReset = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, glueless;
    logic [1:0] bresp, rresp;
    logic [3:0] pinLevelIn, pinDriveOut, pinDriveEnable, boardLevel = 4'hA;
    logic [15:0] irqDef = 16'h0, irqAlt = 16'h0, irqLine;
    logic tx1 = 1'h0, rx1Pin = 1'h0, tx3 = 1'h0, rx3Pin = 1'h0, rx1, rx3;
    logic busRead = 1'h0, busWrite = 1'h0, busUpper = 1'h0, busLower = 1'h0;
    wire [5:0] strobes;
    int fails = 0, compares = 0, cycles = 0;

    always #20 clk = ~clk;

    port_f_and_pin_routing dut_u (.clk(clk), .resetn(resetn),
        .watchdogReset(watchdogReset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinLevelIn(pinLevelIn), .pinDriveOut(pinDriveOut),
        .pinDriveEnable(pinDriveEnable), .irqDefaultPin(irqDef),
        .irqAlternatePin(irqAlt), .irqLine(irqLine),
        .serial1TransmitLine(tx1), .serial1ReceivePin(rx1Pin),
        .serial1ReceiveLine(rx1), .serial3TransmitLine(tx3),
        .serial3ReceivePin(rx3Pin), .serial3ReceiveLine(rx3),
        .busRead(busRead), .busWrite(busWrite), .busUpperByte(busUpper),
        .busLowerByte(busLower), .readStrobeN(strobes[5]),
        .upperWriteStrobeN(strobes[4]), .lowerWriteStrobeN(strobes[3]),
        .writeStrobeN(strobes[2]), .upperByteEnableN(strobes[1]),
        .lowerByteEnableN(strobes[0]), .gluelessStrobeSelect(glueless));

    port_f_board board_u (.pinDriveOut(pinDriveOut),
        .pinDriveEnable(pinDriveEnable), .boardLevel(boardLevel),
        .pinLevelIn(pinLevelIn));

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // ready for the answer is raised with the request and held until it comes
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] e);
        bit done;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        done = 0;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                done = 1;
                bready <= 1'h0;
                checkWord(bresp, e);
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        bit done;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        done = 0;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                done = 1;
                rready <= 1'h0;
                checkWord(rresp, e);
                checkWord(rdata, d);
            end
        end
    endtask

    task automatic testResetValues();
        rd(OUTPUT_LATCH_OFFSET, 32'h0, RESP_OKAY);
        rd(IRQ_HIGH_SELECT_OFFSET, 32'h0, RESP_OKAY);
        rd(IRQ_LOW_SELECT_OFFSET, 32'h0, RESP_OKAY);
        rd(PORT_CONTROL_OFFSET, 32'h0, RESP_OKAY);
        rd(PIN_STATE_OFFSET, 32'hA, RESP_OKAY);
        checkWord(pinDriveEnable, 32'h0);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 8'h55, RESP_SLVERR);
    endtask

    task automatic testPort();
        @(posedge clk);
        boardLevel <= 4'hF;
        wr(PIN_STATE_OFFSET, 8'h05, RESP_OKAY);
        idle(3);
        checkWord(pinDriveEnable, 32'h5);
        rd(PIN_STATE_OFFSET, 32'hA, RESP_OKAY);
        wr(OUTPUT_LATCH_OFFSET, 8'hFF, RESP_OKAY);
        rd(OUTPUT_LATCH_OFFSET, 32'hF, RESP_OKAY);
        checkWord(pinDriveOut, 32'h5);
        @(posedge clk);
        boardLevel <= 4'h0;
        idle(3);
        rd(PIN_STATE_OFFSET, 32'h5, RESP_OKAY);
    endtask

    task automatic testWatchdog();
        wr(IRQ_LOW_SELECT_OFFSET, 8'hFF, RESP_OKAY);
        @(posedge clk);
        watchdogReset <= 1'h1;
        @(posedge clk);
        watchdogReset <= 1'h0;
        rd(IRQ_LOW_SELECT_OFFSET, 32'h0, RESP_OKAY);
        rd(OUTPUT_LATCH_OFFSET, 32'hF, RESP_OKAY);
        checkWord(pinDriveEnable, 32'h5);
    endtask

    task automatic testIrq();
        logic [15:0] sel, exp;
        sel = 16'h81C3;
        wr(IRQ_HIGH_SELECT_OFFSET, sel[15:8], RESP_OKAY);
        wr(IRQ_LOW_SELECT_OFFSET, sel[7:0], RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            irqDef <= k ? 16'hFFFF : 16'h0000;
            irqAlt <= k ? 16'h0000 : 16'hFFFF;
            exp = k ? ~sel : sel;
            idle(4);
            checkWord(irqLine, exp);
        end
    endtask

    task automatic testLoopback();
        logic [7:0] mode;
        for (int k = 0; k < 4; k++) begin
            mode = {k[1:0], 6'h00};
            wr(PORT_CONTROL_OFFSET, mode, RESP_OKAY);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                tx1 <= v[0];
                tx3 <= v[0];
                rx1Pin <= !v[0];
                rx3Pin <= !v[0];
                idle(4);
                checkWord(rx1, mode[7] ? v[0] : !v[0]);
                checkWord(rx3, mode[6] ? v[0] : !v[0]);
            end
        end
    endtask

    task automatic testStrobes();
        logic [5:0] exp;
        logic r, w, u, l;
        for (int m = 0; m < 2; m++) begin
            wr(PORT_CONTROL_OFFSET, m ? 8'h02 : 8'h00, RESP_OKAY);
            checkWord(glueless, m);
            for (int c = 0; c < 16; c++) begin
                {r, w, u, l} = c[3:0];
                @(posedge clk);
                busRead <= r;
                busWrite <= w;
                busUpper <= u;
                busLower <= l;
                idle(1);
                exp[5] = !r;
                exp[4] = !(m == 0 && w && u);
                exp[3] = !(m == 0 && w && l);
                exp[2] = !(m == 1 && w);
                exp[1] = !(m == 1 && (r || w) && u);
                exp[0] = !(m == 1 && (r || w) && l);
                checkWord(strobes, exp);
            end
        end
        @(posedge clk);
        {busRead, busWrite, busUpper, busLower} <= 4'h0;
    endtask

    task automatic testSystemReset();
        @(posedge clk);
        resetn <= 1'h0;
        idle(2);
        checkWord(pinDriveEnable, 32'h0);
        @(posedge clk);
        resetn <= 1'h1;
        rd(OUTPUT_LATCH_OFFSET, 32'h0, RESP_OKAY);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        testResetValues();
        testPort();
        testWatchdog();
        testIrq();
        testLoopback();
        testStrobes();
        testSystemReset();
        end_of_test();
    end
endmodule // port_f_and_pin_routing_bench

bind port_f_and_pin_routing port_f_chk #(.PIN_COUNT(PIN_COUNT)) chk_u (
    .clk(clk), .resetn(resetn), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .pinDriveOut(pinDriveOut), .pinDriveEnable(pinDriveEnable),
    .busRead(busRead), .busWrite(busWrite), .busUpperByte(busUpperByte),
    .busLowerByte(busLowerByte), .readStrobeN(readStrobeN),
    .upperWriteStrobeN(upperWriteStrobeN), .writeStrobeN(writeStrobeN),
    .lowerByteEnableN(lowerByteEnableN),
    .gluelessStrobeSelect(gluelessStrobeSelect));
